// ===== core/acbc_top.sv
// module: comparator b control with ahb-lite register slave and interrupt
//
// Functional notes
// - analog pins reach the comparator only while input connect is one.
// - event flag sets when output meets selected mode, only while enabled.
// - event flag stays set until software clears it; nothing else clears it.
// - interrupt request from event flag only while enable bit six is set.
// - writing enable one switches comparator on; output follows analog inputs.
// - enable zero holds output low and blocks new events.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acbc_top (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic [31:0]      HRDATA,
    output logic             HRESP,
    // analog comparator core
    input  wire logic        CMP_RAW,
    output logic             CMP_CONNECT,
    output logic             CMP_POWER,
    output logic [1:0]       CMP_SRC_SEL,
    output logic [1:0]       CMP_REF_SEL,
    output logic             CMP_OUT,
    // port pins shared with the analog inputs
    input  wire logic [3:0]  PORT_PIN_IN,
    output logic [3:0]       PORT_DIN_EN,
    // interrupt
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic       addr_ok;
    logic       wr_pend_r;
    logic [7:0] wr_offs_r;
    logic       rd_pend_r;
    logic [7:0] rd_offs_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_val;

    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_irqen;

    logic       cmp_b_input_connect_r;
    logic       cmp_b_enable_r;
    logic [2:0] cmp_b_mode_select_r;
    logic [1:0] cmp_b_source_select_r;
    logic [1:0] cmp_b_reference_select_r;

    logic       new_connect;
    logic       new_enable;
    logic [2:0] new_mode;
    logic [1:0] new_src;
    logic [1:0] new_ref;
    logic       src_change;
    logic       ref_change;
    logic       sel_err_evt;

    logic       clr_evt;
    logic       clr_err;
    logic       irq_evt;
    logic       irq_err;

    logic       cmp_b_event_flag_r;
    logic       cmp_b_event_flag_nxt;
    logic       sel_err_r;
    logic       sel_err_nxt;
    logic [7:0] interrupt_enable_reg_r;
    logic [7:0] status_val;

    logic [3:0] port_val_r;

    acbc_evt_if ev ();

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite address phase

    // only whole-word accesses are expected; hsize is not checked
    // upper address bits are not decoded, so the map repeats every 256 bytes
    assign addr_ok = HSEL & HREADY & (HTRANS == acbc_pkg::HTRANS_NONSEQ);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend_r <= 1'b0;
            wr_offs_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok & HWRITE;
            wr_offs_r <= HADDR[7:0];
        end
    end

    // reads take one wait state so hrdata comes from a flop
    // and still sees a write that finished the cycle before
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_pend_r <= 1'b0;
            rd_offs_r <= 8'h00;
        end else if (rd_pend_r) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= addr_ok & ~HWRITE;
            rd_offs_r <= HADDR[7:0];
        end
    end

    assign HREADYOUT = ~rd_pend_r;
    assign HRESP     = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite data phase: write strobes

    assign wr_ctrl  = wr_pend_r & (wr_offs_r == acbc_pkg::OFFS_CTRL);
    assign wr_stat  = wr_pend_r & (wr_offs_r == acbc_pkg::OFFS_STATUS);
    assign wr_irqen = wr_pend_r & (wr_offs_r == acbc_pkg::OFFS_IRQ_EN);
    // unmapped offsets raise no strobe, so such writes are dropped

    ////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_b_input_connect_r    <= acbc_pkg::RST_CONNECT;
            cmp_b_enable_r           <= acbc_pkg::RST_ENABLE;
            cmp_b_mode_select_r      <= acbc_pkg::RST_MODE;
            cmp_b_source_select_r    <= acbc_pkg::RST_SRC;
            cmp_b_reference_select_r <= acbc_pkg::RST_REF;
        end else if (wr_ctrl) begin
            cmp_b_input_connect_r    <= new_connect;
            cmp_b_enable_r           <= new_enable;
            cmp_b_mode_select_r      <= new_mode;
            cmp_b_source_select_r    <= new_src;
            cmp_b_reference_select_r <= new_ref;
        end
    end

    assign new_connect = HWDATA[acbc_pkg::CTRL_CONNECT_BIT];
    assign new_enable  = HWDATA[acbc_pkg::CTRL_ENABLE_BIT];
    assign new_mode    = HWDATA[acbc_pkg::CTRL_MODE_LSB +: acbc_pkg::CTRL_MODE_W];
    assign new_src     = HWDATA[acbc_pkg::CTRL_SRC_LSB +: acbc_pkg::CTRL_SRC_W];
    assign new_ref     = HWDATA[acbc_pkg::CTRL_REF_LSB +: acbc_pkg::CTRL_REF_W];

    assign src_change = new_src != cmp_b_source_select_r;
    assign ref_change = new_ref != cmp_b_reference_select_r;

    // selects are applied anyway; the flag only tells software it erred
    assign sel_err_evt = wr_ctrl & cmp_b_input_connect_r & (src_change | ref_change);

    ////////////////////////////////////////////////////////////////////////
    // analog core drive

    assign CMP_CONNECT = cmp_b_input_connect_r;
    assign CMP_POWER   = cmp_b_enable_r;
    assign CMP_SRC_SEL = cmp_b_source_select_r;
    assign CMP_REF_SEL = cmp_b_reference_select_r;

    ////////////////////////////////////////////////////////////////////////
    // event detection

    assign ev.en   = cmp_b_enable_r;
    assign ev.mode = cmp_b_mode_select_r;
    // an open input switch reads as low, never as a floating level
    assign ev.raw  = CMP_RAW & cmp_b_input_connect_r;

    acbc_event_det u_det (
        .clk    (CLK),
        .arst_n (ARST_N),
        .ev     (ev.det)
    );

    assign CMP_OUT = ev.out;

    ////////////////////////////////////////////////////////////////////////
    // sticky status flags, write one to clear; set beats clear

    assign clr_evt = wr_stat & HWDATA[acbc_pkg::STAT_EVENT_BIT];
    assign clr_err = wr_stat & HWDATA[acbc_pkg::STAT_SELERR_BIT];

    always_comb begin
        cmp_b_event_flag_nxt = cmp_b_event_flag_r;
        if (clr_evt) begin
            cmp_b_event_flag_nxt = 1'b0;
        end
        if (ev.evt) begin
            cmp_b_event_flag_nxt = 1'b1;
        end
    end

    always_comb begin
        sel_err_nxt = sel_err_r;
        if (clr_err) begin
            sel_err_nxt = 1'b0;
        end
        if (sel_err_evt) begin
            sel_err_nxt = 1'b1;
        end
    end

    // no hardware path clears these, interrupt service included
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cmp_b_event_flag_r <= 1'b0;
            sel_err_r          <= 1'b0;
        end else begin
            cmp_b_event_flag_r <= cmp_b_event_flag_nxt;
            sel_err_r          <= sel_err_nxt;
        end
    end

    always_comb begin
        status_val                            = 8'h00;
        status_val[acbc_pkg::STAT_SELERR_BIT] = sel_err_r;
        status_val[acbc_pkg::STAT_CMPOUT_BIT] = ev.out;
        status_val[acbc_pkg::STAT_EVENT_BIT]  = cmp_b_event_flag_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt enable and request

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            interrupt_enable_reg_r <= acbc_pkg::RST_IRQ_EN;
        end else if (wr_irqen) begin
            interrupt_enable_reg_r <= HWDATA[7:0];
        end
    end

    // the live output bit is not a sticky flag and never interrupts
    assign irq_evt = cmp_b_event_flag_r & interrupt_enable_reg_r[acbc_pkg::STAT_EVENT_BIT];
    assign irq_err = sel_err_r & interrupt_enable_reg_r[acbc_pkg::STAT_SELERR_BIT];
    assign IRQ     = irq_evt | irq_err;

    ////////////////////////////////////////////////////////////////////////
    // shared port pins

    // digital buffers off while enabled, avoiding crowbar current
    assign PORT_DIN_EN = cmp_b_enable_r ? 4'h0 : 4'hf;
    // port reads lag the pins and the enable bit by one cycle

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            port_val_r <= acbc_pkg::PORT_FIXED;
        end else if (cmp_b_enable_r) begin
            port_val_r <= acbc_pkg::PORT_FIXED;
        end else begin
            port_val_r <= PORT_PIN_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (rd_offs_r)
            acbc_pkg::OFFS_CTRL: begin
                rd_val[acbc_pkg::CTRL_CONNECT_BIT] = cmp_b_input_connect_r;
                rd_val[acbc_pkg::CTRL_ENABLE_BIT]  = cmp_b_enable_r;
                rd_val[acbc_pkg::CTRL_MODE_LSB +: acbc_pkg::CTRL_MODE_W] = cmp_b_mode_select_r;
                rd_val[acbc_pkg::CTRL_SRC_LSB +: acbc_pkg::CTRL_SRC_W]   = cmp_b_source_select_r;
                rd_val[acbc_pkg::CTRL_REF_LSB +: acbc_pkg::CTRL_REF_W]   = cmp_b_reference_select_r;
            end
            acbc_pkg::OFFS_STATUS: begin
                rd_val[7:0] = status_val;
            end
            acbc_pkg::OFFS_IRQ_EN: begin
                rd_val[7:0] = interrupt_enable_reg_r;
            end
            acbc_pkg::OFFS_PORT: begin
                rd_val[acbc_pkg::PORT_W-1:0] = port_val_r;
            end
            default: begin
                // unmapped offsets read as zero
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // data stands until the next read finishes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hrdata_r <= acbc_pkg::RST_RDATA;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_val;
        end
    end

    assign HRDATA = hrdata_r;

endmodule : acbc_top
`default_nettype wire

// ===== core/acbc_pkg.sv
// package: register map, field layout, reset values and mode codes of comparator b control
`default_nettype none
package acbc_pkg;

    // bus geometry
    localparam int unsigned DATA_W = 32;
    localparam int unsigned OFFS_W = 8;

    // register byte offsets
    localparam logic [7:0] OFFS_CTRL   = 8'h00;
    localparam logic [7:0] OFFS_STATUS = 8'h04;
    localparam logic [7:0] OFFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFFS_PORT   = 8'h0c;

    // control register fields
    localparam int unsigned CTRL_CONNECT_BIT = 0;
    localparam int unsigned CTRL_ENABLE_BIT  = 1;
    localparam int unsigned CTRL_MODE_LSB    = 2;
    localparam int unsigned CTRL_MODE_W      = 3;
    localparam int unsigned CTRL_SRC_LSB     = 5;
    localparam int unsigned CTRL_SRC_W       = 2;
    localparam int unsigned CTRL_REF_LSB     = 7;
    localparam int unsigned CTRL_REF_W       = 2;

    // status and interrupt enable share one layout
    localparam int unsigned STAT_SELERR_BIT = 0;
    localparam int unsigned STAT_CMPOUT_BIT = 1;
    localparam int unsigned STAT_EVENT_BIT  = 6;

    // port register field
    localparam int unsigned PORT_W = 4;

    // values after reset
    localparam logic              RST_CONNECT = 1'b0;
    localparam logic              RST_ENABLE  = 1'b0;
    localparam logic [2:0]        RST_MODE    = 3'h0;
    localparam logic [1:0]        RST_SRC     = 2'h0;
    localparam logic [1:0]        RST_REF     = 2'h0;
    localparam logic [7:0]        RST_IRQ_EN  = 8'h00;
    localparam logic [DATA_W-1:0] RST_RDATA   = 32'h0000_0000;

    // value that port reads return while the digital buffers are off
    localparam logic [3:0] PORT_FIXED = 4'h0;

    // event-mode codes; codes 5 to 7 are reserved and never fire
    localparam logic [2:0] MODE_LOW    = 3'h0;
    localparam logic [2:0] MODE_HIGH   = 3'h1;
    localparam logic [2:0] MODE_RISE   = 3'h2;
    localparam logic [2:0] MODE_FALL   = 3'h3;
    localparam logic [2:0] MODE_TOGGLE = 3'h4;

    // ahb-lite transfer type
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage : acbc_pkg
`default_nettype wire

// ===== core/acbc_evt_if.sv
// interface: control to event detector of comparator b
`timescale 1ns/1ps
`default_nettype none
interface acbc_evt_if;
    logic       en;
    logic [2:0] mode;
    logic       raw;
    logic       out;
    logic       evt;

    modport ctl (output en, output mode, output raw, input out, input evt);
    modport det (input en, input mode, input raw, output out, output evt);
endinterface : acbc_evt_if
`default_nettype wire

// ===== core/acbc_event_det.sv
// module: gated comparator output and event-condition detection
`timescale 1ns/1ps
`default_nettype none
module acbc_event_det (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // control side
    acbc_evt_if.det   ev
);

    logic out_r;
    logic prev_r;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // output forced low while disabled
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_r <= 1'b0;
        end else begin
            out_r <= ev.en & ev.raw;
        end
    end

    // previous output, used for edge modes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= out_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (ev.mode)
            acbc_pkg::MODE_LOW:    hit = ~out_r;
            acbc_pkg::MODE_HIGH:   hit = out_r;
            acbc_pkg::MODE_RISE:   hit = out_r & ~prev_r;
            acbc_pkg::MODE_FALL:   hit = ~out_r & prev_r;
            acbc_pkg::MODE_TOGGLE: hit = out_r ^ prev_r;
            default:               hit = 1'b0;
        endcase
    end

    // en gates the event as well: a fall caused by disabling is no event
    assign ev.evt = hit & ev.en;
    assign ev.out = out_r;

endmodule : acbc_event_det
`default_nettype wire

// ===== tb/acbc_sva.sv
// checker: port-level assertions for comparator b control
`timescale 1ns/1ps
`default_nettype none
module acbc_sva (
    // clock and reset
    input wire logic        CLK,
    input wire logic        ARST_N,
    // bus
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    // comparator, pins, interrupt
    input wire logic        CMP_RAW,
    input wire logic        CMP_CONNECT,
    input wire logic        CMP_POWER,
    input wire logic        CMP_OUT,
    input wire logic [3:0]  PORT_DIN_EN,
    input wire logic        IRQ
);
    logic       ww_r;
    logic [7:0] wa_r;
    logic [7:0] ie_r;
    logic [2:0] mode_r;
    wire take = HSEL & HREADY & (HTRANS == acbc_pkg::HTRANS_NONSEQ);
    ////////////////////////////////////////////////////////////////////////////
    // shadow of write data phases, enough to know mode and mask
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ww_r <= 1'b0;
            wa_r <= 8'h00;
        end else if (HREADY) begin
            ww_r <= take & HWRITE;
            wa_r <= HADDR[7:0];
        end
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ie_r   <= 8'h00;
            mode_r <= 3'h0;
        end else if (ww_r && HREADY) begin
            if (wa_r == acbc_pkg::OFFS_IRQ_EN) ie_r <= HWDATA[7:0];
            if (wa_r == acbc_pkg::OFFS_CTRL) mode_r <= HWDATA[4:2];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    ctrl_write_a: assert property (ww_r && HREADY && wa_r == acbc_pkg::OFFS_CTRL |=>
        CMP_CONNECT == $past(HWDATA[0]) && CMP_POWER == $past(HWDATA[1]))
        else $error("control bits not applied");
    out_gated_a: assert property (CMP_OUT |-> $past(CMP_RAW & CMP_CONNECT & CMP_POWER))
        else $error("output high while gated");
    out_follow_a: assert property (CMP_RAW && CMP_CONNECT && CMP_POWER |=> CMP_OUT)
        else $error("output not following input");
    flag_sticky_a: assert property (IRQ && !(ww_r && (wa_r == acbc_pkg::OFFS_STATUS
        || wa_r == acbc_pkg::OFFS_IRQ_EN)) |=> IRQ) else $error("flag dropped by itself");
    irq_mask_a: assert property (IRQ |-> ie_r[6] || ie_r[0])
        else $error("interrupt while masked");
    high_event_a: assert property (mode_r == acbc_pkg::MODE_HIGH && CMP_POWER && CMP_OUT
        && ie_r[6] && !ww_r |=> IRQ) else $error("high level missed");
    no_event_off_a: assert property ($rose(IRQ) && !$past(ww_r) |-> $past(CMP_POWER))
        else $error("event while disabled");
    port_off_a: assert property (PORT_DIN_EN == (CMP_POWER ? 4'h0 : 4'hf))
        else $error("digital buffers wrong");
    read_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read wait state wrong");
    resp_okay_a: assert property (HRESP == 1'b0) else $error("response not okay");
endmodule // acbc_sva
bind acbc_top acbc_sva u_sva (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CMP_RAW(CMP_RAW), .CMP_CONNECT(CMP_CONNECT),
    .CMP_POWER(CMP_POWER), .CMP_OUT(CMP_OUT), .PORT_DIN_EN(PORT_DIN_EN), .IRQ(IRQ));
`default_nettype wire

// ===== tb/acbc_bench.sv
// testbench: self-checking bench for comparator b control
`timescale 1ns/1ps
`default_nettype none
module acbc_bench;
    logic        clk, arst_n, hsel, hwrite, raw;
    logic [31:0] haddr, hwdata, rd, v;
    logic [1:0]  htrans;
    logic [3:0]  pins;
    wire         rdy, resp, conn, pwr, cout, irq;
    wire  [1:0]  src_sel, ref_sel;
    wire  [3:0]  din_en;
    wire  [31:0] hrdata;
    int          n_mismatch, total_checks, cycles, seed, i, m, ph;
    logic        e;
    acbc_top u_dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HREADYOUT(rdy),
        .HRDATA(hrdata), .HRESP(resp), .CMP_RAW(raw), .CMP_CONNECT(conn), .CMP_POWER(pwr),
        .CMP_SRC_SEL(src_sel), .CMP_REF_SEL(ref_sel), .CMP_OUT(cout),
        .PORT_PIN_IN(pins), .PORT_DIN_EN(din_en), .IRQ(irq));
    ////////////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic finish_test();
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single transfer; waits on ready at each phase
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= acbc_pkg::HTRANS_NONSEQ;
        do @(posedge clk); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        check(rd, exp);
    endtask
    // mode hit for a phase: 0 held low, 1 rise, 2 held high, 3 fall
    function automatic logic hit(input int md, input int p);
        case (md)
            0: hit = (p == 0 || p == 3);
            1: hit = (p == 1 || p == 2);
            2: hit = (p == 1);
            3: hit = (p == 3);
            4: hit = (p == 1 || p == 3);
            default: hit = 1'b0;
        endcase
    endfunction
    task automatic flag_is(input logic x);
        repeat (3) @(posedge clk);
        bus(acbc_pkg::OFFS_STATUS, 1'b0, 32'h0);
        check({31'h0, rd[6]}, {31'h0, x});
        check({31'h0, irq}, {31'h0, x});
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0; arst_n = 1'b0; hsel = 1'b1; hwrite = 1'b0; raw = 1'b0;
        haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; pins = 4'h0;
        n_mismatch = 0; total_checks = 0; cycles = 0; seed = 70360;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        check({27'h0, din_en, irq}, {27'h0, 4'hf, 1'b0});
        rdchk(acbc_pkg::OFFS_CTRL, 32'h0);
        rdchk(acbc_pkg::OFFS_STATUS, 32'h0);
        rdchk(acbc_pkg::OFFS_IRQ_EN, 32'h0);
        rdchk(8'h10, 32'h0);
        // random control with the switch open, raw input wiggling
        for (i = 0; i < 20; i++) begin
            v = $random(seed) & 32'h1fe; // switch stays open while selects change
            bus(acbc_pkg::OFFS_CTRL, 1'b1, v);
            @(posedge clk);
            check({31'h0, pwr}, {31'h0, v[1]});
            check({31'h0, conn}, 32'h0);
            check({28'h0, ref_sel, src_sel}, {28'h0, v[8:5]});
            rdchk(acbc_pkg::OFFS_CTRL, v);
            repeat (4) @(posedge clk) raw <= 1'($random(seed));
            @(posedge clk);
            check({31'h0, cout}, 32'h0);
        end
        raw <= 1'b0;
        bus(acbc_pkg::OFFS_CTRL, 1'b1, 32'h3);
        @(posedge clk);
        check({31'h0, conn}, 32'h1);
        bus(acbc_pkg::OFFS_IRQ_EN, 1'b1, 32'h40);
        // every mode code through low, rise, high, fall
        for (m = 0; m < 8; m++) begin
            bus(acbc_pkg::OFFS_CTRL, 1'b1, {27'h0, 3'(m), 2'b11});
            for (ph = 0; ph < 4; ph++) begin
                if (ph == 0 || ph == 2) bus(acbc_pkg::OFFS_STATUS, 1'b1, 32'h40);
                if (ph == 1) raw <= 1'b1;
                if (ph == 3) raw <= 1'b0;
                e = hit(m, ph) | ((ph % 2) == 1 && hit(m, ph - 1));
                flag_is(e);
            end
        end
        // disabled: no event, output low
        // low mode would fire at once if enable did not gate events
        bus(acbc_pkg::OFFS_CTRL, 1'b1, 32'h1);
        raw <= 1'b1;
        bus(acbc_pkg::OFFS_STATUS, 1'b1, 32'h40);
        flag_is(1'b0);
        check({31'h0, cout}, 32'h0);
        // masking keeps the flag but drops the request
        bus(acbc_pkg::OFFS_CTRL, 1'b1, 32'h7);
        bus(acbc_pkg::OFFS_IRQ_EN, 1'b1, 32'h0);
        @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rdchk(acbc_pkg::OFFS_STATUS, 32'h42);
        bus(acbc_pkg::OFFS_IRQ_EN, 1'b1, 32'h40);
        @(posedge clk);
        check({31'h0, irq}, 32'h1);
        // port reads follow pins only while the comparator is off
        pins <= 4'($random(seed));
        bus(acbc_pkg::OFFS_CTRL, 1'b1, 32'h0);
        repeat (2) @(posedge clk);
        rdchk(acbc_pkg::OFFS_PORT, {28'h0, pins});
        check({28'h0, din_en}, 32'hf);
        bus(acbc_pkg::OFFS_CTRL, 1'b1, 32'h2);
        repeat (2) @(posedge clk);
        rdchk(acbc_pkg::OFFS_PORT, {28'h0, acbc_pkg::PORT_FIXED});
        check({28'h0, din_en}, 32'h0);
        finish_test();
    end
endmodule // acbc_bench
`default_nettype wire
